// ==== dv/mbr_master_model.sv ====
// Purpose: stand-in for the serial master that issues queries
// Assumes: bytes already framed; one query outstanding at a time
// Notes:   transmitter acceptance stalls at random to test hold-off
`default_nettype none
module mbr_master_model
(
  input  wire logic                i_mclk,
  input  wire logic [7:0]          i_rnd,
  output var  mbr_pkg::mbr_rx_type o_rx,
  output logic                     o_tx_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    o_rx = '0;
    o_tx_ready = 1'b0;
  end
  always @(posedge i_mclk)
  begin
    #1;
    o_tx_ready = i_rnd[0] | i_rnd[1];
  end
  // reflected form, all-ones start, lsb first
  function automatic logic [15:0] crc16(input logic [7:0] b[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (b[i])
    begin
      c = c ^ {8'h00, b[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  // 3-cycle gaps stay far below silence, so the bytes form one frame
  task automatic send(input logic [7:0] b[$], input logic [7:0] flip, input int errp);
    logic [15:0] c;
    c = crc16(b);
    b = {b, c[7:0], c[15:8] ^ flip};
    foreach (b[i])
    begin
      @(posedge i_mclk);
      #1;
      o_rx = '{1'b1, i == errp, b[i]};
      @(posedge i_mclk);
      #1;
      o_rx = '{1'b0, 1'b0, ~b[i]};  // released line never shows the old byte
      repeat (2) @(posedge i_mclk);
    end
  endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// Purpose: self-checking bench for the serial query handler
// Assumes: silence and millisecond counts shortened by parameters
// Notes:   map answers after random delays; bytes checked in order
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin n_mismatch++; $display("[ERR] %s exp %h got %h", nm, ex, gt); end end
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  typedef logic [7:0] mbr_bq_type[$];
  localparam int SIL = 50;
  localparam int CPM = 10;
  localparam logic [7:0] A = 8'h05;
  logic                     i_mclk;
  logic                     i_sys_rst;
  logic [5:0]               i_slave_addr;
  logic [9:0]               wait_ms;
  logic [7:0]               rnd;
  logic [7:0]               e;
  logic [15:0]              wsum;
  logic                     o_tx_valid;
  logic [7:0]               o_tx_byte;
  logic                     i_tx_ready;
  mbr_pkg::mbr_rx_type      i_rx;
  mbr_pkg::mbr_map_req_type o_map_req;
  mbr_pkg::mbr_map_req_type mq;
  mbr_pkg::mbr_map_rsp_type i_map_rsp;
  mbr_bq_type               exp_q;
  mbr_bq_type               nil;
  mbr_bq_type               b;
  int                       n_mismatch;
  int                       num_checks;
  int                       cyc;
  int                       d;
  mbr_slave_handler #(.CLKS_PER_BIT(4), .SILENT_CYCLES(SIL), .CYC_PER_MS(CPM)) dut
  (
    .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_rx(i_rx), .i_slave_addr(i_slave_addr),
    .i_response_extra_wait_setting(wait_ms), .o_map_req(o_map_req), .i_map_rsp(i_map_rsp),
    .o_tx_valid(o_tx_valid), .o_tx_byte(o_tx_byte), .i_tx_ready(i_tx_ready)
  );
  mbr_master_model m (.i_mclk(i_mclk), .i_rnd(rnd), .o_rx(i_rx), .o_tx_ready(i_tx_ready));
  initial
  begin
    i_mclk = 1'b0;
    forever #4 i_mclk = ~i_mclk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  initial rnd = 8'h55;
  always @(posedge i_mclk) rnd <= lfsr(rnd);
  // map: coils read as parity of address bits 3:0, registers as address xor 5A5A
  always @(posedge i_mclk)
  begin
    mq = o_map_req;
    #1;
    i_map_rsp.done = mq.valid & ~i_map_rsp.done & rnd[2];
    i_map_rsp.rdata = mq.coil ? {15'h0000, ^mq.addr[3:0]} : mq.addr ^ 16'h5A5A;
    i_map_rsp.exc = mq.addr[15:12] == 4'hF ? 8'h02 : !mq.write ? 8'h00 : mq.addr[15:12] == 4'hE ? 8'h22
                  : (!mq.coil && mq.wdata[15]) ? 8'h21 : 8'h00;
    if (i_map_rsp.done && mq.write && i_map_rsp.exc == 8'h00)
      wsum = wsum ^ mq.addr ^ mq.wdata;
  end
  always @(posedge i_mclk)
    if (o_tx_valid === 1'b1 && i_tx_ready === 1'b1)
    begin
      e = exp_q.size() != 0 ? exp_q.pop_front() : 'x;
      `CHK("tx_byte", e, o_tx_byte)
    end
  always @(posedge i_mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      results();
    end
  end
  task automatic results();
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  function automatic mbr_bq_type f6(input logic [7:0] a, f, input logic [15:0] w1, w2);
    return '{a, f, w1[15:8], w1[7:0], w2[15:8], w2[7:0]};
  endfunction
  task automatic push(input mbr_bq_type r);
    logic [15:0] c;
    c = m.crc16(r);
    if (r.size() != 0)
      exp_q = {exp_q, r, c[7:0], c[15:8]};
  endtask
  task automatic finish(input logic rest);
    for (int k = 0; k < 4000 && exp_q.size() != 0; k++)
      @(posedge i_mclk);
    `CHK("pending", 0, exp_q.size())
    if (rest)
      repeat (SIL + 60) @(posedge i_mclk);
  endtask
  // k: 0 silent, 1 echo, 2 exception x, 3 explicit reply r
  task automatic run(input mbr_bq_type q, input logic [1:0] k, input logic [7:0] x, input mbr_bq_type r);
    if (k == 2'h1)
      r = q;
    if (k == 2'h2)
      r = '{q[0], q[1] | 8'h80, x};
    push(r);
    m.send(q, 8'h00, -1);
    finish(1'b1);
  endtask
  initial
  begin
    n_mismatch = 0;
    num_checks = 0;
    cyc = 0;
    wsum = 16'h0000;
    i_sys_rst = 1'b1;
    i_slave_addr = 6'h05;
    wait_ms = 10'h000;
    i_map_rsp = '0;
    repeat (3) @(posedge i_mclk);
    #1;
    i_sys_rst = 1'b0;
    repeat (10) @(posedge i_mclk);
    run(f6(A, 8'h08, 16'h1234, 16'h5678), 2'h0, 8'h00, nil);
    run(f6(A, 8'h03, 16'h0011, 16'h0002), 2'h3, 8'h00, '{A, 8'h03, 8'h04, 8'h5A, 8'h4B, 8'h5A, 8'h48});
    run(f6(A, 8'h03, 16'h0000, 16'h0004), 2'h3, 8'h00,
        '{A, 8'h03, 8'h08, 8'h5A, 8'h5A, 8'h5A, 8'h5B, 8'h5A, 8'h58, 8'h5A, 8'h59});
    run(f6(A, 8'h03, 16'h0000, 16'h0005), 2'h2, 8'h03, nil);
    run(f6(A, 8'h01, 16'h0006, 16'h0006), 2'h3, 8'h00, '{A, 8'h01, 8'h01, 8'h13});
    run(f6(A, 8'h01, 16'h0000, 16'h0020), 2'h3, 8'h00, '{A, 8'h01, 8'h04, 8'hCB, 8'h34, 8'hCB, 8'h34});
    run(f6(A, 8'h01, 16'h0000, 16'h0000), 2'h2, 8'h03, nil);
    run(f6(A, 8'h01, 16'h0000, 16'h0021), 2'h2, 8'h03, nil);
    run(f6(A, 8'h06, 16'h0002, 16'h1234), 2'h1, 8'h00, nil);
    run(f6(A, 8'h06, 16'h0002, 16'h8000), 2'h2, 8'h21, nil);
    run(f6(A, 8'h05, 16'h0001, 16'hFF00), 2'h1, 8'h00, nil);
    `CHK("map_wr", 16'h1235, wsum)
    run(f6(A, 8'h05, 16'h0001, 16'h1234), 2'h2, 8'h03, nil);
    run(f6(A, 8'h06, 16'hE000, 16'h0001), 2'h2, 8'h22, nil);
    run(f6(A, 8'h03, 16'hF000, 16'h0001), 2'h2, 8'h02, nil);
    run('{A, 8'h0F, 8'h00, 8'h00, 8'h00, 8'h0A, 8'h02, rnd, lfsr(rnd) & 8'h03}, 2'h1, 8'h00, nil);
    wsum = 16'h0000;
    run('{A, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h00, 8'h02}, 2'h1, 8'h00, nil);
    run('{A, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h04, 8'h00, 8'h01, 8'h80, 8'h00}, 2'h2, 8'h21, nil);
    `CHK("map_wr", 16'h0003, wsum)
    run('{A, 8'h08, rnd, lfsr(rnd), 8'h00}, 2'h1, 8'h00, nil);
    run('{A, 8'h07, 8'h00, 8'h00}, 2'h2, 8'h01, nil);
    run(f6(8'h06, 8'h03, 16'h0000, 16'h0001), 2'h0, 8'h00, nil);
    run(f6(8'h00, 8'h06, 16'h0002, 16'h0007), 2'h0, 8'h00, nil);
    `CHK("map_wr", 16'h0006, wsum)
    run(f6(8'h00, 8'h03, 16'h0000, 16'h0001), 2'h0, 8'h00, nil);
    run('{A, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00}, 2'h0, 8'h00, nil);
    m.send(f6(A, 8'h03, 16'h0000, 16'h0001), 8'h01, -1);
    finish(1'b1);
    m.send(f6(A, 8'h03, 16'h0000, 16'h0001), 8'h00, 2);
    finish(1'b1);
    // extra wait of 3 ms must come on top of the silence
    #1;
    wait_ms = 10'h003;
    b = '{A, 8'h08, 8'h00, 8'h01};
    push(b);
    m.send(b, 8'h00, -1);
    for (d = 0; d < 500 && o_tx_valid !== 1'b1; d++)
      @(posedge i_mclk);
    `CHK("reply_delay", 1'b1, d >= SIL + 3 * CPM - 4 && d <= SIL + 3 * CPM + 10)
    finish(1'b1);
    results();
  end
endmodule
`default_nettype wire

// ==== verilog/mbr_crc16.sv ====
// Purpose: byte-wise crc-16 engine
// Assumes: at most one byte per cycle
// Notes:   clear and a byte in one cycle start a new sum
`default_nettype none
module mbr_crc16
(
  input  wire logic        i_mclk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_clear,
  input  wire logic        i_valid,
  input  wire logic [7:0]  i_byte,
  output logic      [15:0] o_crc
);
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c ^ {8'h00, b};
    for (int k = 0; k < 8; k++)
    begin
      r = r[0] ? ((r >> 1) ^ mbr_pkg::CRC_POLY_REFL) : (r >> 1);
    end
    return r;
  endfunction

  logic [15:0] base;
  assign base = i_clear ? mbr_pkg::CRC_INIT : o_crc;

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_crc <= mbr_pkg::CRC_INIT;
    else
      o_crc <= i_valid ? crc_step(base, i_byte) : base;
  end
endmodule
`default_nettype wire

// ==== verilog/mbr_pkg.sv ====
// Purpose: shared constants and types for the query handler
// Assumes: 125 MHz device clock, bytes framed by an outside receiver
// Notes:   crc register starts at all ones, reflected polynomial
// How it works
// - read up to 32 coils or 4 registers
// - single coil and register writes, one item
// - multi writes: 32 coils, 4 registers max
// - crc-16 over whole message, both sides
// - frames bounded by 24 bit-time silence
// - short header gap means no answer
// - reply after silence plus extra wait
// - loopback returns query unchanged
// - successful writes echo the query
// - reads return address, function, data
// - errors give address, function, code, crc
// - exception function is function plus 80h
// - codes 01h, 02h, 03h for basic errors
// - code 21h for out-of-range write
// - code 22h for restricted operations
// - broadcasts never answered, reads not broadcast
// - foreign slave address silently dropped
// - line error or bad length dropped
// - gap timing violation dropped
// - two-byte fields sent upper byte first, except the crc, lower byte first
// - own address 1 to 32, 0 broadcast
// - coil count 0 or over 32 gives 03h
// - start coil field is coil minus one
// - first coil in least-significant bit
`default_nettype none
package mbr_pkg;
  localparam int CLK_HZ           = 125_000_000;
  localparam int SILENT_BITS      = 24;
  localparam int DEF_CLKS_PER_BIT = 13021;
  localparam int WAIT_UNIT_MS     = 1;
  localparam int CYC_PER_MS       = CLK_HZ / 1000 * WAIT_UNIT_MS;
  localparam logic [9:0] MAX_WAIT_MS = 10'h3E8;
  localparam logic [15:0] CRC_INIT      = 16'hFFFF;
  localparam logic [15:0] CRC_POLY_REFL = 16'hA001;
  localparam logic [7:0] FC_RD_COIL  = 8'h01;
  localparam logic [7:0] FC_RD_REG   = 8'h03;
  localparam logic [7:0] FC_WR_COIL  = 8'h05;
  localparam logic [7:0] FC_WR_REG   = 8'h06;
  localparam logic [7:0] FC_LOOP     = 8'h08;
  localparam logic [7:0] FC_WR_COILS = 8'h0F;
  localparam logic [7:0] FC_WR_REGS  = 8'h10;
  localparam logic [7:0] EXC_FLAG    = 8'h80;
  localparam logic [7:0] EX_FUNC     = 8'h01;
  localparam logic [7:0] EX_ADDR     = 8'h02;
  localparam logic [7:0] EX_DATA     = 8'h03;
  localparam logic [7:0] EX_RANGE    = 8'h21;
  localparam logic [7:0] EX_LOCK     = 8'h22;
  localparam logic [15:0] COIL_ON    = 16'hFF00;
  localparam logic [15:0] COIL_OFF   = 16'h0000;
  localparam logic [15:0] MAX_COILS  = 16'h0020;
  localparam logic [15:0] MAX_REGS   = 16'h0004;
  localparam int MAX_DBYTES = 8;
  localparam logic [4:0] MIN_LEN   = 5'h04;
  localparam logic [4:0] SHORT_LEN = 5'h08;
  localparam logic [4:0] MULTI_HDR = 5'h09;
  localparam logic [4:0] DATA_POS  = 5'h07;
  localparam logic [4:0] RESP_HDR  = 5'h03;
  localparam logic [4:0] CRC_BYTES = 5'h02;
  localparam int RXBUF_LEN = 17;
  localparam logic [5:0] SLAVE_MAX = 6'h20;

  typedef struct packed {
    logic       valid;
    logic       err;
    logic [7:0] data;
  } mbr_rx_type;

  typedef struct packed {
    logic        valid;
    logic        write;
    logic        coil;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mbr_map_req_type;

  typedef struct packed {
    logic        done;
    logic [15:0] rdata;
    logic [7:0]  exc;
  } mbr_map_rsp_type;

  typedef enum logic [2:0] {S_IDLE, S_CHECK, S_ACCESS, S_WAIT, S_SEND} mbr_state_type;
  typedef enum logic [1:0] {K_ECHO, K_READ, K_EXC} mbr_kind_type;
endpackage
`default_nettype wire

// ==== verilog/mbr_slave_handler.sv ====
// Purpose: query checker, executor and responder of the serial slave
// Assumes: bytes come from a receiver on i_mclk; map answers per item
// Notes:   address and wait setting are slow straps, synchronised
`default_nettype none
module mbr_slave_handler #(
  parameter int CLKS_PER_BIT  = mbr_pkg::DEF_CLKS_PER_BIT,
  parameter int SILENT_CYCLES = mbr_pkg::SILENT_BITS * CLKS_PER_BIT,
  parameter int CYC_PER_MS    = mbr_pkg::CYC_PER_MS
)
(
  input  wire logic                     i_mclk,
  input  wire logic                     i_sys_rst,
  input  wire mbr_pkg::mbr_rx_type      i_rx,
  input  wire logic [5:0]               i_slave_addr,
  input  wire logic [9:0]               i_response_extra_wait_setting,
  output var  mbr_pkg::mbr_map_req_type o_map_req,
  input  wire mbr_pkg::mbr_map_rsp_type i_map_rsp,
  output logic                          o_tx_valid,
  output logic [7:0]                    o_tx_byte,
  input  wire logic                     i_tx_ready
);
  if (CLKS_PER_BIT < 1 || SILENT_CYCLES < 1 || CYC_PER_MS < 1)
  begin : g_bad_param
    $error("timing parameters must be positive");
  end

  mbr_pkg::mbr_state_type st_r;
  mbr_pkg::mbr_kind_type  kind_r;
  mbr_pkg::mbr_map_req_type item;
  logic [5:0]  addr_s1_r, addr_s2_r;
  logic [9:0]  wait_s1_r, wait_s2_r, wait_lim, ms_r;
  logic [31:0] gap_r, pre_r;
  logic        gap_ok, take, first, frame_end, in_frame_r, bad_r;
  logic [4:0]  len_r, item_idx, idx_r, tx_idx_r, tx_len;
  logic [7:0]  rxb_r [mbr_pkg::RXBUF_LEN];
  logic [7:0]  rd_r [mbr_pkg::MAX_DBYTES];
  logic [7:0]  fc, bc, code_r, fmt_code, body;
  logic [15:0] base, cnt, rx_crc, tx_crc;
  logic [5:0]  n_items, n_r;
  logic [4:0]  n_bytes, nb_r;
  logic        bcast, mine, len_ok, ok_frame, rd_like, go_access, more;
  logic        wait_done, tx_acc, tx_last_acc, tx_body_r;

  // straps come from pins, so two flops first
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      addr_s1_r <= 6'h00;
      addr_s2_r <= 6'h00;
      wait_s1_r <= 10'h000;
      wait_s2_r <= 10'h000;
    end
    else
    begin
      addr_s1_r <= i_slave_addr;
      addr_s2_r <= addr_s1_r;
      wait_s1_r <= i_response_extra_wait_setting;
      wait_s2_r <= wait_s1_r;
    end
  end

  // line silence since the last byte, saturating
  assign gap_ok    = (gap_r == 32'(SILENT_CYCLES));
  assign take      = i_rx.valid && (st_r == mbr_pkg::S_IDLE);
  assign first     = take && !in_frame_r;
  assign frame_end = in_frame_r && gap_ok;

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      gap_r <= 32'h0;
    else if (i_rx.valid)
      gap_r <= 32'h0;
    else if (!gap_ok)
      gap_r <= gap_r + 32'h1;
  end

  // bytes while busy are not stored but still restart the gap
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      in_frame_r <= 1'b0;
      bad_r      <= 1'b0;
      len_r      <= 5'h00;
    end
    else if (first)
    begin
      in_frame_r <= 1'b1;
      bad_r      <= !gap_ok || i_rx.err;
      len_r      <= 5'h01;
    end
    else if (take)
    begin
      bad_r <= bad_r || i_rx.err || (len_r == 5'(mbr_pkg::RXBUF_LEN));
      if (len_r != 5'(mbr_pkg::RXBUF_LEN))
        len_r <= len_r + 5'h01;
    end
    else if (frame_end)
      in_frame_r <= 1'b0;
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (int k = 0; k < mbr_pkg::RXBUF_LEN; k++)
        rxb_r[k] <= 8'h00;
    end
    else if (first)
      rxb_r[0] <= i_rx.data;
    else if (take && len_r != 5'(mbr_pkg::RXBUF_LEN))
      rxb_r[len_r] <= i_rx.data;
  end

  mbr_crc16 u_rx_crc
  (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_clear   (first),
    .i_valid   (take),
    .i_byte    (i_rx.data),
    .o_crc     (rx_crc)
  );

  // query decode; crc bytes included make a good sum zero
  assign fc    = rxb_r[1];
  assign base  = {rxb_r[2], rxb_r[3]};
  assign cnt   = {rxb_r[4], rxb_r[5]};
  assign bc    = rxb_r[6];
  assign bcast = (rxb_r[0] == 8'h00);
  assign mine  = (rxb_r[0] == {2'h0, addr_s2_r}) && (addr_s2_r != 6'h00)
                 && (addr_s2_r <= mbr_pkg::SLAVE_MAX);

  always_comb
  begin
    len_ok   = 1'b1;
    fmt_code = 8'h00;
    n_items  = 6'h01;
    n_bytes  = 5'h00;
    case (fc)
      mbr_pkg::FC_RD_COIL:
      begin
        len_ok  = (len_r == mbr_pkg::SHORT_LEN);
        n_items = cnt[5:0];
        n_bytes = 5'((cnt[5:0] + 6'h07) >> 3);
        if (cnt == 16'h0 || cnt > mbr_pkg::MAX_COILS)
          fmt_code = mbr_pkg::EX_DATA;
      end
      mbr_pkg::FC_RD_REG:
      begin
        len_ok  = (len_r == mbr_pkg::SHORT_LEN);
        n_items = cnt[5:0];
        n_bytes = {1'b0, cnt[2:0], 1'b0};
        if (cnt == 16'h0 || cnt > mbr_pkg::MAX_REGS)
          fmt_code = mbr_pkg::EX_DATA;
      end
      mbr_pkg::FC_WR_COIL:
      begin
        len_ok = (len_r == mbr_pkg::SHORT_LEN);
        if (cnt != mbr_pkg::COIL_ON && cnt != mbr_pkg::COIL_OFF)
          fmt_code = mbr_pkg::EX_DATA;
      end
      mbr_pkg::FC_WR_REG:
        len_ok = (len_r == mbr_pkg::SHORT_LEN);
      mbr_pkg::FC_LOOP:
        len_ok = 1'b1;
      mbr_pkg::FC_WR_COILS:
      begin
        len_ok  = (bc <= 8'(mbr_pkg::MAX_DBYTES)) && (len_r == mbr_pkg::MULTI_HDR + bc[4:0]);
        n_items = cnt[5:0];
        if (cnt == 16'h0 || cnt > mbr_pkg::MAX_COILS || bc != 8'((cnt[5:0] + 6'h07) >> 3))
          fmt_code = mbr_pkg::EX_DATA;
      end
      mbr_pkg::FC_WR_REGS:
      begin
        len_ok  = (bc <= 8'(mbr_pkg::MAX_DBYTES)) && (len_r == mbr_pkg::MULTI_HDR + bc[4:0]);
        n_items = cnt[5:0];
        if (cnt == 16'h0 || cnt > mbr_pkg::MAX_REGS || bc != {4'h0, cnt[2:0], 1'b0})
          fmt_code = mbr_pkg::EX_DATA;
      end
      default:
        fmt_code = mbr_pkg::EX_FUNC;
    endcase
  end

  assign ok_frame  = !bad_r && (len_r >= mbr_pkg::MIN_LEN) && (rx_crc == 16'h0)
                     && len_ok && (mine || bcast);
  assign rd_like   = (fc == mbr_pkg::FC_RD_COIL) || (fc == mbr_pkg::FC_RD_REG)
                     || (fc == mbr_pkg::FC_LOOP) || (fmt_code == mbr_pkg::EX_FUNC);
  assign go_access = (st_r == mbr_pkg::S_CHECK) && ok_frame && (fmt_code == 8'h00)
                     && (fc != mbr_pkg::FC_LOOP) && !(bcast && rd_like);
  assign more      = ({1'b0, idx_r} + 6'h01) != n_r; // six bits, so a 32-item run can end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      st_r   <= mbr_pkg::S_IDLE;
      kind_r <= mbr_pkg::K_ECHO;
      code_r <= 8'h00;
      idx_r  <= 5'h00;
      n_r    <= 6'h00;
      nb_r   <= 5'h00;
    end
    else
    begin
      unique case (st_r)
        mbr_pkg::S_IDLE:
          if (frame_end)
            st_r <= mbr_pkg::S_CHECK;
        mbr_pkg::S_CHECK:
        begin
          code_r <= fmt_code;
          n_r    <= n_items;
          nb_r   <= n_bytes;
          idx_r  <= 5'h00;
          if (!ok_frame || (bcast && (rd_like || fmt_code != 8'h00)))
            st_r <= mbr_pkg::S_IDLE;
          else if (fmt_code != 8'h00)
          begin
            kind_r <= mbr_pkg::K_EXC;
            st_r   <= mbr_pkg::S_WAIT;
          end
          else if (fc == mbr_pkg::FC_LOOP)
          begin
            kind_r <= mbr_pkg::K_ECHO;
            st_r   <= mbr_pkg::S_WAIT;
          end
          else
          begin
            kind_r <= rd_like ? mbr_pkg::K_READ : mbr_pkg::K_ECHO;
            st_r   <= mbr_pkg::S_ACCESS;
          end
        end
        mbr_pkg::S_ACCESS:
          if (i_map_rsp.done)
          begin
            idx_r <= idx_r + 5'h01;
            if (i_map_rsp.exc != 8'h00)
            begin
              code_r <= i_map_rsp.exc;
              kind_r <= mbr_pkg::K_EXC;
              st_r   <= bcast ? mbr_pkg::S_IDLE : mbr_pkg::S_WAIT;
            end
            else if (!more)
              st_r <= bcast ? mbr_pkg::S_IDLE : mbr_pkg::S_WAIT;
          end
        mbr_pkg::S_WAIT:
          if (wait_done)
            st_r <= mbr_pkg::S_SEND;
        mbr_pkg::S_SEND:
          if (tx_last_acc)
            st_r <= mbr_pkg::S_IDLE;
        default:
          st_r <= mbr_pkg::S_IDLE;
      endcase
    end
  end

  // one map item per handshake; coil fields are one below the coil
  assign item_idx = (st_r == mbr_pkg::S_CHECK) ? 5'h00 : idx_r + 5'h01;

  always_comb
  begin
    item.valid = 1'b1;
    item.write = !rd_like;
    item.coil  = (fc == mbr_pkg::FC_RD_COIL) || (fc == mbr_pkg::FC_WR_COIL)
                 || (fc == mbr_pkg::FC_WR_COILS);
    item.addr  = base + {11'h0, item_idx} + {15'h0, item.coil};
    case (fc)
      mbr_pkg::FC_WR_COIL:
        item.wdata = {15'h0, cnt == mbr_pkg::COIL_ON};
      mbr_pkg::FC_WR_REG:
        item.wdata = cnt;
      mbr_pkg::FC_WR_COILS:
        item.wdata = {15'h0, rxb_r[mbr_pkg::DATA_POS + {3'h0, item_idx[4:3]}][item_idx[2:0]]};
      mbr_pkg::FC_WR_REGS:
        item.wdata = {rxb_r[mbr_pkg::DATA_POS + {item_idx[3:0], 1'b0}],
                      rxb_r[mbr_pkg::DATA_POS + {item_idx[3:0], 1'b1}]};
      default:
        item.wdata = 16'h0;
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_map_req <= '0;
    else if (go_access || (st_r == mbr_pkg::S_ACCESS && i_map_rsp.done && i_map_rsp.exc == 8'h00 && more))
      o_map_req <= item;
    else if (st_r == mbr_pkg::S_ACCESS && i_map_rsp.done)
      o_map_req.valid <= 1'b0;
  end

  // unread coil bits stay zero
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      for (int k = 0; k < mbr_pkg::MAX_DBYTES; k++)
        rd_r[k] <= 8'h00;
    end
    else if (st_r == mbr_pkg::S_CHECK)
    begin
      for (int k = 0; k < mbr_pkg::MAX_DBYTES; k++)
        rd_r[k] <= 8'h00;
    end
    else if (st_r == mbr_pkg::S_ACCESS && i_map_rsp.done && i_map_rsp.exc == 8'h00 && kind_r == mbr_pkg::K_READ)
    begin
      if (fc == mbr_pkg::FC_RD_COIL)
        rd_r[{1'b0, idx_r[4:3]}][idx_r[2:0]] <= i_map_rsp.rdata[0];
      else
      begin
        rd_r[{idx_r[1:0], 1'b0}] <= i_map_rsp.rdata[15:8];
        rd_r[{idx_r[1:0], 1'b1}] <= i_map_rsp.rdata[7:0];
      end
    end
  end

  // extra wait in milliseconds on top of the silence already seen
  assign wait_lim  = (wait_s2_r > mbr_pkg::MAX_WAIT_MS) ? mbr_pkg::MAX_WAIT_MS : wait_s2_r;
  assign wait_done = (st_r == mbr_pkg::S_WAIT) && (ms_r >= wait_lim);

  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      pre_r <= 32'h0;
      ms_r  <= 10'h000;
    end
    else if (st_r != mbr_pkg::S_WAIT)
    begin
      pre_r <= 32'h0;
      ms_r  <= 10'h000;
    end
    else if (pre_r == 32'(CYC_PER_MS - 1))
    begin
      pre_r <= 32'h0;
      ms_r  <= ms_r + 10'h001;
    end
    else
      pre_r <= pre_r + 32'h1;
  end

  // response bytes; crc is recomputed so an echo repeats it exactly
  always_comb
  begin
    unique case (kind_r)
      mbr_pkg::K_ECHO:
        tx_len = len_r - mbr_pkg::CRC_BYTES;
      mbr_pkg::K_READ:
        tx_len = mbr_pkg::RESP_HDR + nb_r;
      default:
        tx_len = mbr_pkg::RESP_HDR;
    endcase
    if (kind_r == mbr_pkg::K_ECHO)
      body = rxb_r[tx_idx_r];
    else if (tx_idx_r == 5'h00)
      body = rxb_r[0];
    else if (tx_idx_r == 5'h01)
      body = (kind_r == mbr_pkg::K_EXC) ? (rxb_r[1] | mbr_pkg::EXC_FLAG) : rxb_r[1];
    else if (tx_idx_r == 5'h02)
      body = (kind_r == mbr_pkg::K_EXC) ? code_r : {3'h0, nb_r};
    else
      body = rd_r[3'(tx_idx_r - mbr_pkg::RESP_HDR)];
  end

  assign tx_acc      = o_tx_valid && i_tx_ready;
  assign tx_last_acc = tx_acc && (tx_idx_r == tx_len + mbr_pkg::CRC_BYTES);

  mbr_crc16 u_tx_crc
  (
    .i_mclk    (i_mclk),
    .i_sys_rst (i_sys_rst),
    .i_clear   (wait_done),
    .i_valid   (tx_acc && tx_body_r),
    .i_byte    (o_tx_byte),
    .o_crc     (tx_crc)
  );

  // one idle cycle per byte lets the crc settle before its bytes go out
  always_ff @(posedge i_mclk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_tx_valid <= 1'b0;
      o_tx_byte  <= 8'h00;
      tx_idx_r   <= 5'h00;
      tx_body_r  <= 1'b0;
    end
    else if (wait_done)
      tx_idx_r <= 5'h00;
    else if (tx_acc)
      o_tx_valid <= 1'b0;
    else if (st_r == mbr_pkg::S_SEND && !o_tx_valid && tx_idx_r != tx_len + mbr_pkg::CRC_BYTES)
    begin
      o_tx_valid <= 1'b1;
      tx_body_r  <= (tx_idx_r < tx_len);
      tx_idx_r   <= tx_idx_r + 5'h01;
      if (tx_idx_r < tx_len)
        o_tx_byte <= body;
      else if (tx_idx_r == tx_len)
        o_tx_byte <= tx_crc[7:0];
      else
        o_tx_byte <= tx_crc[15:8];
    end
  end

  property p_no_bcast_reply;
    @(posedge i_mclk) disable iff (i_sys_rst) st_r == mbr_pkg::S_SEND |-> rxb_r[0] != 8'h00;
  endproperty
  a_no_bcast_reply: assert property (p_no_bcast_reply)
    else $error("reply to a broadcast query");

  property p_own_addr;
    @(posedge i_mclk) disable iff (i_sys_rst) o_tx_valid |-> mine;
  endproperty
  a_own_addr: assert property (p_own_addr)
    else $error("reply to a foreign address");

  property p_exc_fc;
    @(posedge i_mclk) disable iff (i_sys_rst)
      tx_acc && kind_r == mbr_pkg::K_EXC && tx_idx_r == 5'h02 |-> o_tx_byte == (rxb_r[1] | mbr_pkg::EXC_FLAG);
  endproperty
  a_exc_fc: assert property (p_exc_fc)
    else $error("exception function code wrong");

  property p_echo;
    @(posedge i_mclk) disable iff (i_sys_rst)
      tx_acc && kind_r == mbr_pkg::K_ECHO |-> o_tx_byte == rxb_r[tx_idx_r - 5'h01];
  endproperty
  a_echo: assert property (p_echo)
    else $error("echo differs from query");

  property p_read_hdr;
    @(posedge i_mclk) disable iff (i_sys_rst)
      tx_acc && kind_r == mbr_pkg::K_READ && tx_idx_r == 5'h01 |-> o_tx_byte == rxb_r[0];
  endproperty
  a_read_hdr: assert property (p_read_hdr)
    else $error("read reply address wrong");

  property p_coil_count;
    @(posedge i_mclk) disable iff (i_sys_rst)
      $rose(o_map_req.valid) && fc == mbr_pkg::FC_RD_COIL |-> n_r >= 6'h01 && n_r <= 6'h20;
  endproperty
  a_coil_count: assert property (p_coil_count)
    else $error("coil read with illegal count");

  property p_single;
    @(posedge i_mclk) disable iff (i_sys_rst)
      $rose(o_map_req.valid) && (fc == mbr_pkg::FC_WR_COIL || fc == mbr_pkg::FC_WR_REG) |-> n_r == 6'h01;
  endproperty
  a_single: assert property (p_single)
    else $error("single write with several items");

  property p_coil_addr;
    @(posedge i_mclk) disable iff (i_sys_rst)
      o_map_req.valid && o_map_req.coil |-> o_map_req.addr == base + {11'h0, idx_r} + 16'h0001;
  endproperty
  a_coil_addr: assert property (p_coil_addr)
    else $error("coil address not field plus one");

  property p_delay;
    @(posedge i_mclk) disable iff (i_sys_rst)
      st_r == mbr_pkg::S_WAIT ##1 st_r == mbr_pkg::S_SEND |-> $past(ms_r) == $past(wait_lim);
  endproperty
  a_delay: assert property (p_delay)
    else $error("response started before wait ended");

  property p_crc_good;
    @(posedge i_mclk) disable iff (i_sys_rst)
      $past(st_r) == mbr_pkg::S_CHECK && st_r != mbr_pkg::S_IDLE |-> $past(rx_crc) == 16'h0 && !$past(bad_r);
  endproperty
  a_crc_good: assert property (p_crc_good)
    else $error("bad or mistimed query accepted");
endmodule
`default_nettype wire
